// File: fgr_bus_cond.sv
`timescale 1ns/1ps
`default_nettype none

// =============================================================
// Shared constants and types
// =============================================================
package fgr_pkg;
  // Fixed seven-bit bus address of the gauge
  localparam logic [6:0] DEV_BUS_ADDR = 7'h36;
  // Byte returned once the pointer has run past the top
  localparam logic [7:0] PAST_TOP_BYTE = 8'hFF;
  // Highest memory location
  localparam logic [7:0] TOP_ADDR = 8'hFF;
  // Pointer and bit counter constants
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_STEP = 4'h1;

  // One-cycle bus events seen by the protocol engine
  typedef struct packed {
    logic start;     // Start or repeated start
    logic stop;      // Stop
    logic scl_rise;  // Clock rising edge
    logic scl_fall;  // Clock falling edge
    logic sda;       // Data level in the same cycle
  } fgr_bus_ev_t;

  // Protocol states
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_START_MEMORY_POINTER, S_START_MEMORY_POINTER_ACK, S_WR_SINK, S_TX, S_TX_ACK
  } fgr_state_t;
endpackage

// =============================================================
// Bus condition detector
// =============================================================
module fgr_bus_cond (
  // Clock and synchronised reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus levels as seen on the wires
  input wire logic scl_in,
  input wire logic sda_in,
  // Decoded events, registered
  output var fgr_pkg::fgr_bus_ev_t ev
);
  // Previous levels, used for edge detection
  logic scl_prev_reg;
  logic sda_prev_reg;
  // Decoded events from current and previous levels
  wire logic start_w = scl_prev_reg & scl_in & sda_prev_reg & ~sda_in;
  wire logic stop_w = scl_prev_reg & scl_in & ~sda_prev_reg & sda_in;
  wire logic rise_w = ~scl_prev_reg & scl_in;
  wire logic fall_w = scl_prev_reg & ~scl_in;

  // Idle bus is high on both wires, so reset to high avoids a false stop or clock rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      ev <= '0;
    end else begin
      scl_prev_reg <= scl_in;
      sda_prev_reg <= sda_in;
      ev <= '{start: start_w, stop: stop_w, scl_rise: rise_w, scl_fall: fall_w, sda: sda_in};
    end
  end
endmodule // fgr_bus_cond

`default_nettype wire

// File: fgr_i2c_read.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: Master reads: write address, repeated start, read.
// R2: Master reads both register bytes together.
// R3: First byte from start pointer, MSB first.
// R4: Pointer advances after each byte's last bit.
// R5: Reads past top location return FFh.
// R6: Reserved locations return undefined data.
// R7: Master ends read with no-ack, stop/restart.
// R8: Answer only address 0110110, ack after direction.
// R9: Device drives data except master ack cycles.
// R10: High byte even address, low byte odd.
// R11: After no-ack, release data, await start.
module fgr_i2c_read (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Two-wire bus, data is open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Memory read port, combinational data for mem_addr
  output logic [7:0] mem_addr,
  input wire logic [7:0] mem_rd_data
);
  // =============================================================
  // Reset release
  // =============================================================
  logic rst_meta_reg;
  logic rst_n;

  // Release asynchronously applied reset through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // =============================================================
  // Bus events
  // =============================================================
  fgr_pkg::fgr_bus_ev_t ev;

  fgr_bus_cond u_cond (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev)
  );

  // =============================================================
  // Protocol state
  // =============================================================
  fgr_pkg::fgr_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;       // Clock rises in current byte
  logic [7:0] shift_reg, shift_next;   // Receive or transmit byte
  logic [7:0] ptr_reg, ptr_next;       // Memory pointer
  logic past_top_reg, past_top_next;   // Pointer ran beyond top
  logic rw_reg, rw_next;               // Direction bit of last address
  logic oe_reg, oe_next;               // Pull data low
  logic ack_ok_reg, ack_ok_next;       // Master acknowledged last byte

  // Byte to send next: beyond the top the gauge answers all ones
  // Reserved locations pass through unmasked; their content is left undefined
  wire logic [7:0] load_byte = past_top_reg ? fgr_pkg::PAST_TOP_BYTE : mem_rd_data; // [R5] [R6]
  // Byte boundary reached on this falling clock edge
  wire logic byte_done = ev.scl_fall && (cnt_reg == fgr_pkg::BITS_PER_BYTE);
  // Received byte carries our bus address
  wire logic addr_hit = (shift_reg[7:1] == fgr_pkg::DEV_BUS_ADDR);
  // Shifted receive byte
  wire logic [7:0] shift_in = {shift_reg[6:0], ev.sda};

  // Next-state decode; stop and start override any byte in flight
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    past_top_next = past_top_reg;
    rw_next = rw_reg;
    oe_next = oe_reg;
    ack_ok_next = ack_ok_reg;
    if (ev.stop) begin
      // Stop returns the bus to idle
      state_next = fgr_fgr_idle();
      oe_next = 1'b0;
    end else if (ev.start) begin
      // Start or repeated start: listen for an address
      state_next = fgr_pkg::S_ADDR;
      cnt_next = fgr_pkg::CNT_ZERO;
      oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        fgr_pkg::S_IDLE: begin
          // Wait for a start
        end
        fgr_pkg::S_ADDR: begin
          if (ev.scl_rise) begin
            shift_next = shift_in;
            cnt_next = cnt_reg + fgr_pkg::CNT_STEP;
          end else if (byte_done) begin
            if (addr_hit) begin
              // Acknowledge in the clock after the direction bit
              oe_next = 1'b1; // [R8]
              rw_next = shift_reg[0];
              state_next = fgr_pkg::S_ADDR_ACK;
            end else begin
              state_next = fgr_pkg::S_IDLE;
            end
          end
        end
        fgr_pkg::S_ADDR_ACK: begin
          if (ev.scl_fall) begin
            cnt_next = fgr_pkg::CNT_ZERO;
            if (rw_reg) begin
              // Keep the line and present the byte at the pointer, MSB first
              shift_next = load_byte; // [R3] [R9]
              oe_next = ~load_byte[7];
              state_next = fgr_pkg::S_TX;
            end else begin
              oe_next = 1'b0;
              state_next = fgr_pkg::S_START_MEMORY_POINTER;
            end
          end
        end
        fgr_pkg::S_START_MEMORY_POINTER: begin
          if (ev.scl_rise) begin
            shift_next = shift_in;
            cnt_next = cnt_reg + fgr_pkg::CNT_STEP;
          end else if (byte_done) begin
            // Load the start memory pointer and acknowledge it
            ptr_next = shift_reg;
            past_top_next = 1'b0;
            oe_next = 1'b1;
            state_next = fgr_pkg::S_START_MEMORY_POINTER_ACK;
          end
        end
        fgr_pkg::S_START_MEMORY_POINTER_ACK: begin
          if (ev.scl_fall) begin
            oe_next = 1'b0;
            cnt_next = fgr_pkg::CNT_ZERO;
            state_next = fgr_pkg::S_WR_SINK;
          end
        end
        fgr_pkg::S_WR_SINK: begin
          // Write data is outside this path: acknowledged and dropped
          if (ev.scl_rise) begin
            cnt_next = cnt_reg + fgr_pkg::CNT_STEP;
          end else if (byte_done) begin
            oe_next = 1'b1;
            state_next = fgr_pkg::S_START_MEMORY_POINTER_ACK;
          end
        end
        fgr_pkg::S_TX: begin
          if (ev.scl_rise) begin
            cnt_next = cnt_reg + fgr_pkg::CNT_STEP;
          end else if (byte_done) begin
            // Last bit out: release for the master's ack, step pointer below the top location
            oe_next = 1'b0; // [R9]
            ack_ok_next = 1'b0;
            state_next = fgr_pkg::S_TX_ACK;
            if (ptr_reg == fgr_pkg::TOP_ADDR) begin
              past_top_next = 1'b1; // [R5]
            end else begin
              ptr_next = ptr_reg + fgr_pkg::PTR_STEP; // [R4] [R10]
            end
          end else if (ev.scl_fall) begin
            // Next bit while the clock is low
            shift_next = {shift_reg[6:0], 1'b0};
            oe_next = ~shift_reg[6];
          end
        end
        fgr_pkg::S_TX_ACK: begin
          if (ev.scl_rise) begin
            ack_ok_next = ~ev.sda;
          end else if (ev.scl_fall) begin
            cnt_next = fgr_pkg::CNT_ZERO;
            if (ack_ok_reg) begin
              // Next byte goes out right after the ack clock
              shift_next = load_byte; // [R4]
              oe_next = ~load_byte[7];
              state_next = fgr_pkg::S_TX;
            end else begin
              // No-ack: line stays released, wait for a start
              oe_next = 1'b0; // [R11]
              state_next = fgr_pkg::S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Idle state name, used by the stop override path
  function automatic fgr_pkg::fgr_state_t fgr_fgr_idle();
    return fgr_pkg::S_IDLE;
  endfunction

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= fgr_pkg::S_IDLE;
      cnt_reg <= fgr_pkg::CNT_ZERO;
      shift_reg <= '0;
      ptr_reg <= fgr_pkg::PTR_RESET;
      past_top_reg <= 1'b0;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      past_top_reg <= past_top_next;
      rw_reg <= rw_next;
      oe_reg <= oe_next;
      ack_ok_reg <= ack_ok_next;
    end
  end

  // =============================================================
  // Outputs
  // =============================================================
  // Open drain: the line is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe = oe_reg;
  assign mem_addr = ptr_reg;

  // =============================================================
  // Checks
  // =============================================================
  a_addr_ack_match: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    (state_reg == fgr_pkg::S_ADDR_ACK && $past(state_reg) != fgr_pkg::S_ADDR_ACK)
      |-> (shift_reg[7:1] == fgr_pkg::DEV_BUS_ADDR) && sda_oe)
    else $error("address acknowledged without a match");

  a_first_byte_msb: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    (state_reg == fgr_pkg::S_TX && $past(state_reg) == fgr_pkg::S_ADDR_ACK)
      |-> shift_reg == $past(load_byte) && sda_oe == ~shift_reg[7])
    else $error("first byte not taken from pointer MSB first");

  a_ptr_advance: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    (state_reg == fgr_pkg::S_TX_ACK && $past(state_reg) == fgr_pkg::S_TX)
      |-> ptr_reg == $past(ptr_reg) + fgr_pkg::PTR_STEP || past_top_reg)
    else $error("pointer did not advance after byte");

  a_past_top_ones: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    (past_top_reg && state_reg == fgr_pkg::S_TX && $past(state_reg) == fgr_pkg::S_TX_ACK)
      |-> shift_reg == fgr_pkg::PAST_TOP_BYTE)
    else $error("byte beyond top is not all ones");

  a_ack_released: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    state_reg == fgr_pkg::S_TX_ACK |-> !sda_oe)
    else $error("data driven during master ack");

  a_even_odd_pair: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
    (state_reg == fgr_pkg::S_TX_ACK && $past(state_reg) == fgr_pkg::S_TX && !past_top_reg)
      |-> ptr_reg[0] != $past(ptr_reg[0]))
    else $error("pointer skipped the paired byte");

  a_nack_idle: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    (state_reg == fgr_pkg::S_TX_ACK && ev.scl_fall && !ack_ok_reg && !ev.start && !ev.stop)
      |=> (state_reg == fgr_pkg::S_IDLE && !sda_oe) [*2])
    else $error("no-ack did not release the bus");
endmodule // fgr_i2c_read

`default_nettype wire

// File: fgr_mst_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Two-wire bus master model
// ==========================================
module fgr_mst_model (
  // Clock
  input wire logic clk,
  // Resolved data wire
  input wire logic sda,
  // Driven bus clock and data pull-down
  output logic scl,
  output logic sda_pull
);
  // Half bus period in clk cycles, far above the two-cycle sync delay
  localparam int HALF = 10;
  // Idle bus: both lines high
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Wait n clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One bit: data set mid-low, sampled mid-high
  task automatic bit_xfer(input logic b, output logic seen);
    tick(HALF / 2);
    sda_pull <= ~b;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF / 2);
    seen = sda;
    tick(HALF / 2);
    scl <= 1'b0;
  endtask
  // Start or repeated start: data falls while clock is high
  task automatic start;
    tick(HALF / 2);
    sda_pull <= 1'b0;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
  endtask
  // Stop: data rises while clock is high, bus left idle
  task automatic stop;
    tick(HALF / 2);
    sda_pull <= 1'b1;
    tick(HALF / 2);
    scl <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b0;
    tick(HALF);
  endtask
  // Send a byte MSB first, return the slave acknowledge
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], s);
    end
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask
  // Receive a byte, then acknowledge or not; ln is the wire in the ack cycle
  task automatic get_byte(input logic ack, output logic [7:0] d, output logic ln);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      d[i] = s;
    end
    bit_xfer(~ack, ln);
  endtask
endmodule // fgr_mst_model

`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Read path testbench
// ==========================================
module testbench;
  logic clk;
  logic rstn;
  logic scl;
  logic pull;
  logic sda_out;
  logic sda_oe;
  logic [7:0] mem_addr;
  logic [7:0] mem_rd_data;
  wire sda;
  int n_mismatch;
  int compares;
  logic [7:0] got [$];
  // Pull-up wire: low when either party pulls
  assign sda = (sda_oe ? sda_out : 1'b1) & ~pull;
  // Memory pattern, nibble swap so bit order shows
  function automatic logic [7:0] mem_val(input logic [7:0] a);
    return {a[3:0], a[7:4]} ^ 8'hA5;
  endfunction
  assign mem_rd_data = mem_val(mem_addr);

  fgr_i2c_read u_dut (.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .mem_addr(mem_addr), .mem_rd_data(mem_rd_data));
  fgr_mst_model u_mst (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));

  // ==========================================
  // Checking and ending
  // ==========================================
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================
  // Shared transaction: pointer write, restart, read n bytes
  // ==========================================
  task automatic point_and_read(input logic [7:0] ptr, input int n);
    logic a;
    logic ln;
    logic [7:0] d;
    got.delete();
    u_mst.start();
    u_mst.put_byte({7'h36, 1'b0}, a);
    check("addr_w_ack", {7'h00, a}, 8'h01);
    u_mst.put_byte(ptr, a);
    check("ptr_ack", {7'h00, a}, 8'h01);
    u_mst.start();
    u_mst.put_byte({7'h36, 1'b1}, a);
    check("addr_r_ack", {7'h00, a}, 8'h01);
    for (int i = 0; i < n; i++) begin
      u_mst.get_byte(i < n - 1, d, ln);
      got.push_back(d);
    end
    check("nack_line", {7'h00, ln}, 8'h01);
    u_mst.stop();
    check("oe_idle", {7'h00, sda_oe}, 8'h00);
  endtask

  // ==========================================
  // Scenarios
  // ==========================================
  // Foreign addresses get no acknowledge
  task automatic t_wrong_addr;
    logic a;
    logic [6:0] bad [3] = '{7'h37, 7'h76, 7'h34};
    foreach (bad[i]) begin
      u_mst.start();
      u_mst.put_byte({bad[i], 1'b1}, a);
      check("foreign_ack", {7'h00, a}, 8'h00);
      u_mst.stop();
      check("foreign_oe", {7'h00, sda_oe}, 8'h00);
    end
  endtask
  // Two-byte register: high byte at even address first
  task automatic t_pair_read;
    point_and_read(8'h10, 2);
    check("pair_hi", got[0], mem_val(8'h10));
    check("pair_lo", got[1], mem_val(8'h11));
    check("ptr_after", mem_addr, 8'h12);
  endtask
  // Long burst: pointer steps once per byte
  task automatic t_burst;
    point_and_read(8'h2A, 5);
    foreach (got[i]) begin
      check("burst", got[i], mem_val(8'h2A + 8'(i)));
    end
  endtask
  // Across the top location, then a fresh pointer recovers
  task automatic t_top;
    point_and_read(8'hFE, 4);
    check("top_fe", got[0], mem_val(8'hFE));
    check("top_ff", got[1], mem_val(8'hFF));
    check("past_1", got[2], 8'hFF);
    check("past_2", got[3], 8'hFF);
    point_and_read(8'h02, 2);
    check("recover", got[0], mem_val(8'h02));
  endtask
  // Write bytes are acked and dropped; a read ends in a repeated start,
  // then a read with no pointer byte continues from the current pointer
  task automatic t_sink_restart;
    logic a;
    logic ln;
    logic [7:0] d;
    u_mst.start();
    u_mst.put_byte({7'h36, 1'b0}, a);
    u_mst.put_byte(8'h40, a);
    u_mst.put_byte(8'h5A, a);
    check("sink_ack", {7'h00, a}, 8'h01);
    u_mst.start();
    u_mst.put_byte({7'h36, 1'b1}, a);
    u_mst.get_byte(1'b0, d, ln);
    check("sink_rd", d, mem_val(8'h40));
    u_mst.start();
    u_mst.put_byte({7'h36, 1'b1}, a);
    check("cur_ack", {7'h00, a}, 8'h01);
    u_mst.get_byte(1'b0, d, ln);
    check("cur_ptr", d, mem_val(8'h41));
    check("cur_nack", {7'h00, ln}, 8'h01);
    u_mst.stop();
  endtask

  // ==========================================
  // Clock, reset, sequence, watchdog
  // ==========================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    n_mismatch = 0;
    compares = 0;
    rstn = 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_wrong_addr();
    t_pair_read();
    t_burst();
    t_top();
    t_sink_restart();
    stop_test();
  end
  // About 7000 cycles expected; generous margin
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
endmodule // testbench

`default_nettype wire
